// ---- design/adc_serial_port.sv ----
// Device end of the converter serial host port: shift logic, ready pin, write path.
// Assumes serial clock, select and data in arrive asynchronously and are far
// slower than clk; register reads are served from a flat read port.
`timescale 1ns/10ps
// Operation
// - Output bit changes after serial clock falls, stable at next rise.
// - Output pin released whenever select is high.
// - Selected and not reading, output pin shows data ready.
// - Ready indicator low when a finished result waits to be read.
// - Unread result: indicator goes high before next result update.
// - Output shift register loads from whichever register is read.
// - Received words go to register named by address bits.
// - Clock source select in mode register sets crystal pin role.
// - Port works with select tied low, three wires only.
module adc_serial_port
	import adc_port_pkg::*;
#(
	parameter int DATA_BITS = DATA_W
) (
	input  wire logic              clk,
	input  wire logic              resetn,
	input  wire logic              sclk,
	input  wire logic              cs_n,
	input  wire logic              din,
	output logic                   dout_rdy_o,
	output logic                   dout_rdy_oe,
	input  wire logic              result_done,
	input  wire logic              result_update_soon,
	output logic [ADDR_W-1:0]      rd_addr,
	input  wire logic [DATA_W-1:0] rd_data,
	output logic                   result_read,
	output reg_write_t             wr_word,
	output logic                   wr_valid,
	input  wire logic              wr_ready,
	output logic                   crystal_or_clock_pin_o,
	output logic                   crystal_or_clock_pin_oe,
	output logic                   crystal_enable,
	output clk_src_t               clock_source_select
);
	logic [1:0]        rst_sync_ff;
	logic              rst_n;
	logic [2:0]        sclk_sync_ff;
	logic [1:0]        cs_sync_ff;
	logic [1:0]        din_sync_ff;
	logic              sclk_rise;
	logic              sclk_fall;
	logic              cs_n_s;
	port_state_t       state_ff;
	logic [5:0]        bit_cnt_ff;
	logic [DATA_W-1:0] in_sh_ff;
	logic [DATA_W-1:0] out_sh_ff;
	logic [ADDR_W-1:0] addr_ff;
	logic              dout_ff;
	logic              ready_n_ff;
	logic [DATA_W-1:0] mode_ff;
	logic [DATA_W-1:0] nxt_in_sh;
	reg_write_t        fifo_in;
	logic              fifo_in_valid;
	logic              fifo_in_ready;
	logic              last_bit;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_sync_ff <= 3'h7;
			cs_sync_ff   <= 2'h3;
			din_sync_ff  <= 2'h0;
		end else begin
			sclk_sync_ff <= {sclk_sync_ff[1:0], sclk};
			cs_sync_ff   <= {cs_sync_ff[0], cs_n};
			din_sync_ff  <= {din_sync_ff[0], din};
		end
	end
	assign sclk_rise = sclk_sync_ff[1] && !sclk_sync_ff[2];
	assign sclk_fall = !sclk_sync_ff[1] && sclk_sync_ff[2];
	assign cs_n_s    = cs_sync_ff[1];

	assign nxt_in_sh = {in_sh_ff[DATA_W-2:0], din_sync_ff[1]};
	assign last_bit  = (state_ff == ST_COMM) ? (bit_cnt_ff == 6'h07)
	                                        : (bit_cnt_ff == 6'(DATA_BITS - 1));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff   <= ST_COMM;
			bit_cnt_ff <= 6'h00;
			in_sh_ff   <= '0;
			addr_ff    <= '0;
		end else if (cs_n_s) begin
			state_ff   <= ST_COMM;
			bit_cnt_ff <= 6'h00;
		end else if (sclk_rise && !(state_ff == ST_WR && last_bit && !fifo_in_ready)) begin
			in_sh_ff   <= nxt_in_sh;
			bit_cnt_ff <= last_bit ? 6'h00 : bit_cnt_ff + 6'h01;
			if (last_bit) begin
				case (state_ff)
					ST_COMM: begin
						addr_ff  <= nxt_in_sh[COMM_ADDR_LSB +: ADDR_W];
						state_ff <= nxt_in_sh[COMM_READ_BIT] ? ST_RD : ST_WR;
					end
					default: begin
						state_ff <= ST_COMM;
					end
				endcase
			end
		end
	end

	assign fifo_in       = {addr_ff, nxt_in_sh};
	assign fifo_in_valid = !cs_n_s && sclk_rise && state_ff == ST_WR && last_bit;

	word_fifo #(
		.WIDTH ($bits(reg_write_t)),
		.DEPTH (FIFO_DEPTH)
	) u_wr_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_data   (fifo_in),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.out_data  (wr_word),
		.out_valid (wr_valid),
		.out_ready (wr_ready)
	);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_ff <= MODE_RST;
		end else if (fifo_in_valid && fifo_in_ready && addr_ff == MODE_REG_ADDR) begin
			mode_ff <= nxt_in_sh;
		end
	end
	assign clock_source_select     = clk_src_t'(mode_ff[CLKSEL_LSB +: 2]);
	assign crystal_enable          = (clock_source_select == CLK_XTAL);
	assign crystal_or_clock_pin_oe = (clock_source_select == CLK_INT_OUT);
	// No clock generator in this block, so the driven level stays low
	assign crystal_or_clock_pin_o  = 1'b0;

	// Load output shifter from read target
	// Address bits are complete only in the word that includes the eighth bit
	assign rd_addr = (state_ff == ST_COMM) ? nxt_in_sh[COMM_ADDR_LSB +: ADDR_W] : addr_ff;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_sh_ff <= '0;
			dout_ff   <= 1'b1;
		end else if (state_ff == ST_COMM && sclk_rise && last_bit && nxt_in_sh[COMM_READ_BIT]) begin
			out_sh_ff <= rd_data;
		end else if (state_ff == ST_RD && sclk_fall) begin
			dout_ff   <= out_sh_ff[DATA_BITS-1];
			out_sh_ff <= {out_sh_ff[DATA_W-2:0], 1'b0};
		end
	end
	assign result_read = !cs_n_s && state_ff == ST_RD && sclk_rise && last_bit;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ready_n_ff <= 1'b1;
		end else if (result_update_soon) begin
			ready_n_ff <= 1'b1;
		end else if (result_done) begin
			// A new result beats a read ending in the same cycle
			ready_n_ff <= 1'b0;
		end else if (result_read) begin
			ready_n_ff <= 1'b1;
		end
	end

	assign dout_rdy_oe = !cs_n_s;
	assign dout_rdy_o  = (state_ff == ST_RD) ? dout_ff : ready_n_ff;

	property p_release;
		@(posedge clk) disable iff (!rst_n) cs_sync_ff[1] |-> !dout_rdy_oe;
	endproperty
	a_release: assert property (p_release) else $error("pin driven while deselected");

	property p_ready_low;
		@(posedge clk) disable iff (!rst_n)
			(result_done && !result_update_soon) |=> !ready_n_ff;
	endproperty
	a_ready_low: assert property (p_ready_low) else $error("ready not shown");

	property p_ready_high;
		@(posedge clk) disable iff (!rst_n) result_update_soon |=> ready_n_ff;
	endproperty
	a_ready_high: assert property (p_ready_high) else $error("ready not cleared");

	property p_shift_fall;
		@(posedge clk) disable iff (!rst_n) $changed(dout_ff) |-> $past(sclk_fall);
	endproperty
	a_shift_fall: assert property (p_shift_fall) else $error("output moved off falling edge");

	property p_rdy_mux;
		@(posedge clk) disable iff (!rst_n) (state_ff != ST_RD) |-> dout_rdy_o == ready_n_ff;
	endproperty
	a_rdy_mux: assert property (p_rdy_mux) else $error("ready not on pin");

	property p_write;
		@(posedge clk) disable iff (!rst_n)
			(fifo_in_valid && fifo_in_ready && addr_ff == MODE_REG_ADDR) |=> mode_ff == $past(nxt_in_sh);
	endproperty
	a_write: assert property (p_write) else $error("mode write lost");

	property p_wr_push;
		@(posedge clk) disable iff (!rst_n) (fifo_in_valid && fifo_in_ready) |=> wr_valid;
	endproperty
	a_wr_push: assert property (p_wr_push) else $error("write word not queued");

	property p_rd_load;
		@(posedge clk) disable iff (!rst_n)
			(state_ff == ST_COMM && sclk_rise && last_bit && nxt_in_sh[COMM_READ_BIT] && !cs_n_s)
			|=> out_sh_ff == $past(rd_data);
	endproperty
	a_rd_load: assert property (p_rd_load) else $error("read shifter not loaded");
endmodule

// ---- design/adc_port_pkg.sv ----
// Shared constants and carrier types for the converter serial port.
// Assumes a single 100 MHz system clock domain.
package adc_port_pkg;
	localparam int CLK_MHZ            = 100;
	localparam int ADDR_W             = 6;
	localparam int DATA_W             = 24;
	localparam int FIFO_DEPTH         = 8;
	// Communications byte layout
	localparam int COMM_READ_BIT      = 6;
	localparam int COMM_ADDR_LSB      = 0;
	localparam logic [ADDR_W-1:0] MODE_REG_ADDR = 6'h01;
	// Field position of clock source select inside the converter mode register
	localparam int CLKSEL_LSB         = 2;
	localparam logic [1:0] CLKSEL_RST = 2'h0;
	localparam logic [DATA_W-1:0] MODE_RST = 24'h000000;
	// Ready pin goes high this many nanoseconds before a new result is published
	localparam int READY_LEAD_NS      = 100;
	localparam int READY_LEAD_CYC     = (READY_LEAD_NS * CLK_MHZ + 999) / 1000;

	typedef enum logic [1:0] {
		CLK_INT     = 2'b00,
		CLK_INT_OUT = 2'b01,
		CLK_EXT     = 2'b10,
		CLK_XTAL    = 2'b11
	} clk_src_t;

	typedef enum logic [1:0] {
		ST_COMM = 2'b00,
		ST_WR   = 2'b01,
		ST_RD   = 2'b10
	} port_state_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} reg_write_t;
endpackage

// ---- design/word_fifo.sv ----
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an already synchronised active-low reset.
`timescale 1ns/10ps
module word_fifo #(
	parameter int WIDTH = 30,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wr_ff;
	logic [AW-1:0]    rd_ff;
	logic [AW:0]      cnt_ff;
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
	assign out_valid = (cnt_ff != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_ff[rd_ff];

	always_ff @(posedge clk) begin
		if (push) begin
			mem_ff[wr_ff] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ff  <= '0;
			rd_ff  <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) begin
				wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
			end
			if (pop) begin
				rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
			end
			cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	property p_no_overflow;
		@(posedge clk) disable iff (!rst_n) cnt_ff <= (AW+1)'(DEPTH);
	endproperty
	a_no_overflow: assert property (p_no_overflow) else $error("fifo count past depth");
endmodule

// ---- bench/host_model.sv ----
// Host end of the serial port: drives serial clock, select and data in.
// Assumes callers start at a falling clk edge; bench resolves the shared pin.
`timescale 1ns/10ps
module host_model (
	output logic      sclk,
	output logic      cs_n,
	output logic      din,
	input  wire logic dout
);
	localparam time HALF = 80ns;
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		din  = 1'b0;
	end
	task automatic sel(input logic v);
		cs_n = v;
	endtask
	// Comm byte first, select left as it is
	task automatic shift(input logic [7:0] comm, input logic [23:0] wd, input int nbits,
			output logic [23:0] rd);
		logic [31:0] sh;
		sh   = {comm, wd};
		rd   = '0;
		for (int i = 0; i < nbits; i++) begin
			sclk = 1'b0;
			// Set after fall, held over rise
			din  = sh[31-i];
			#HALF;
			sclk = 1'b1;
			rd   = {rd[22:0], dout};
			#HALF;
		end
	endtask
	task automatic xfer(input logic [7:0] comm, input logic [23:0] wd, input int nbits,
			output logic [23:0] rd);
		cs_n = 1'b0;
		#HALF;
		shift(comm, wd, nbits, rd);
		cs_n = 1'b1;
		// Released line must not keep its last value
		din  = ~din;
		#HALF;
	endtask
endmodule

// ---- bench/tb.sv ----
// Self-checking bench for the converter serial port.
// Assumes host_model as far side and a flat register read port answered here.
`timescale 1ns/10ps
module tb;
	import adc_port_pkg::*;
	logic             clk, resetn, sclk, cs_n, din, dout_o, dout_oe, tgl, dout_w;
	logic             r_done, r_soon, r_read, wr_valid, wr_ready, ck_o, ck_oe, xtal_en;
	logic [ADDR_W-1:0] rd_addr;
	logic [DATA_W-1:0] rd_data;
	logic [23:0]      rd;
	reg_write_t       wr_word, q[$];
	clk_src_t         src;
	int               errors, n_tests, n_read;
	adc_serial_port dut (.clk(clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .din(din),
		.dout_rdy_o(dout_o), .dout_rdy_oe(dout_oe), .result_done(r_done),
		.result_update_soon(r_soon), .rd_addr(rd_addr), .rd_data(rd_data),
		.result_read(r_read), .wr_word(wr_word), .wr_valid(wr_valid), .wr_ready(wr_ready),
		.crystal_or_clock_pin_o(ck_o), .crystal_or_clock_pin_oe(ck_oe),
		.crystal_enable(xtal_en), .clock_source_select(src));
	host_model host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout_w));
	// Undriven pin wanders so a stale level cannot pass
	assign dout_w  = dout_oe ? dout_o : tgl;
	assign rd_data = {18'h2A5C3, rd_addr};
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		tgl <= ~tgl;
		if (r_read)
			n_read <= n_read + 1;
		if (wr_valid && wr_ready)
			q.push_back(wr_word);
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic waitn(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic t_ready();
		chk(dout_oe, 1'b0, "oe idle");
		host.sel(1'b0);
		waitn(5);
		chk(dout_oe, 1'b1, "oe sel");
		chk(dout_w, 1'b1, "not ready");
		r_done = 1'b1;
		waitn(1);
		r_done = 1'b0;
		waitn(5);
		chk(dout_w, 1'b0, "ready low");
		r_soon = 1'b1;
		waitn(1);
		r_soon = 1'b0;
		waitn(5);
		chk(dout_w, 1'b1, "ready high");
		host.sel(1'b1);
		waitn(5);
		chk(dout_oe, 1'b0, "oe off");
		$display("test ready done");
	endtask
	task automatic t_clksel();
		for (int i = 0; i < 4; i++) begin
			host.xfer({2'b00, MODE_REG_ADDR}, 24'(i) << CLKSEL_LSB, 32, rd);
			waitn(6);
			chk(q.size(), 1, "mode word");
			chk(q.pop_front(), {MODE_REG_ADDR, 24'(i) << CLKSEL_LSB}, "mode data");
			chk(src, i, "clksel");
			chk(ck_oe, i == 1, "clk out");
			chk(ck_o, 1'b0, "clk out level");
			chk(xtal_en, i == 3, "xtal");
		end
		$display("test clksel done");
	endtask
	task automatic t_read();
		r_done = 1'b1;
		waitn(1);
		r_done = 1'b0;
		waitn(1);
		chk(dout_o, 1'b0, "ready before read");
		host.xfer(8'h45, 24'h000000, 32, rd);
		chk(rd, {18'h2A5C3, 6'h05}, "read data");
		chk(n_read, 1, "read pulse");
		chk(dout_o, 1'b1, "read clears ready");
		$display("test read done");
	endtask
	task automatic t_fifo();
		wr_ready = 1'b0;
		for (int i = 0; i < FIFO_DEPTH; i++)
			host.xfer(8'h02, 24'hA00000 + 24'(i), 32, rd);
		chk(q.size(), 0, "stalled");
		chk(wr_valid, 1'b1, "valid held");
		wr_ready = 1'b1;
		waitn(12);
		chk(q.size(), FIFO_DEPTH, "drained");
		for (int i = 0; i < FIFO_DEPTH; i++)
			chk(q.pop_front(), {6'h02, 24'hA00000 + 24'(i)}, "order");
		$display("test fifo done");
	endtask
	task automatic t_abort();
		host.xfer(8'h03, 24'h5A5A5A, 12, rd);
		host.xfer(8'h03, 24'h123456, 32, rd);
		waitn(6);
		chk(q.size(), 1, "abort count");
		chk(q.pop_front(), {6'h03, 24'h123456}, "after abort");
		$display("test abort done");
	endtask
	// Select held low across frames: three-wire use
	task automatic t_3wire();
		host.sel(1'b0);
		waitn(4);
		host.shift(8'h03, 24'h0000AA, 32, rd);
		host.shift(8'h03, 24'h0000BB, 32, rd);
		host.shift(8'h47, 24'h000000, 32, rd);
		chk(dout_oe, 1'b1, "oe held");
		chk(rd, {18'h2A5C3, 6'h07}, "3-wire read");
		waitn(6);
		chk(q.size(), 2, "3-wire writes");
		chk(q.pop_front(), {6'h03, 24'h0000AA}, "3-wire first");
		chk(q.pop_front(), {6'h03, 24'h0000BB}, "3-wire second");
		host.sel(1'b1);
		waitn(4);
		$display("test 3wire done");
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		resetn   = 1'b0;
		r_done   = 1'b0;
		r_soon   = 1'b0;
		wr_ready = 1'b1;
		tgl      = 1'b0;
		errors   = 0;
		n_tests  = 0;
		n_read   = 0;
		waitn(2);
		resetn = 1'b1;
		waitn(6);
		t_ready();
		t_clksel();
		t_read();
		t_fifo();
		t_abort();
		t_3wire();
		results();
	end
	initial begin
		#500us;
		errors++;
		results();
	end
endmodule
